// File: sfi_pkg.sv
package sfi_pkg;
    // register offsets
    localparam logic [15:0] FIFO_STATE_OFS  = 16'h0000;
    localparam logic [15:0] DATA_EVENT_OFS  = 16'h0001;
    // reset values
    localparam logic [15:0] FIFO_STATE_RST  = 16'h0000;
    localparam logic [15:0] DATA_EVENT_RST  = 16'h0000;
    // fifo state register fields
    localparam int unsigned FLUSH_BIT       = 15;
    localparam int unsigned UFLOW_BIT       = 14;
    localparam int unsigned OFLOW_BIT       = 13;
    localparam int unsigned COUNT_LSB       = 0;
    localparam int unsigned COUNT_W         = 11;
    // data event register fields
    localparam int unsigned LEVEL_BIT       = 15;
    localparam int unsigned SLOT_LSB        = 0;
    localparam int unsigned SLOT_N          = 12;
    // flag bank layout: slots first, then the fifo flags
    localparam int unsigned FLAG_N          = 15;
    localparam int unsigned FB_UFLOW        = 12;
    localparam int unsigned FB_OFLOW        = 13;
    localparam int unsigned FB_LEVEL        = 14;
endpackage

// File: sfi_flag_if.sv
`timescale 1ns/1ps
interface sfi_flag_if #(
    parameter int unsigned N = 1
);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic [N-1:0] q;
    // bank holds the sticky bits, user raises set and clear requests
    modport bank (input set, input clr, output q);
    modport user (output set, output clr, input q);
endinterface

// File: sfi_flag_bank.sv
`timescale 1ns/1ps
module sfi_flag_bank #(
    parameter int unsigned N = 1
) (
    // clock, reset, enable
    input  wire logic clk_sys_i,
    input  wire logic rstn_i,
    input  wire logic ce_i,
    // flag requests and state
    sfi_flag_if.bank  flg
);
    typedef struct packed {
        logic [N-1:0] flag;
    } sfi_bank_st_t;

    sfi_bank_st_t st_q;
    sfi_bank_st_t st_d;
    logic [N-1:0] nxt;

    // set beats clear so an event in the clearing cycle survives
    for (genvar g = 0; g < N; g++)
    begin : g_bit
        assign nxt[g] = flg.set[g] | (st_q.flag[g] & ~flg.clr[g]);
    end

    always_comb
    begin
        st_d      = st_q;
        st_d.flag = nxt;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            st_q <= '0;
        else if (ce_i)
            st_q <= st_d;
    end

    assign flg.q = st_q.flag;

    a_set_beats_clr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (ce_i && flg.set != '0) |=> ((flg.q & $past(flg.set)) == $past(flg.set)))
        else $error("flag lost its set");

    a_idle_holds: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (ce_i && flg.set == '0 && flg.clr == '0) |=> $stable(flg.q))
        else $error("flag changed without request");
endmodule

// File: sfi_status_top.sv
`timescale 1ns/1ps
module sfi_status_top #(
    parameter int unsigned FIFO_DEPTH = 1024,
    parameter int unsigned WR_BYTES   = 2
) (
    // clock, reset, enable
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    // register port from the serial control port
    input  wire logic [15:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    output logic             reg_rvalid_o,
    // fifo traffic
    input  wire logic        fifo_push_i,
    input  wire logic        fifo_pop_i,
    input  wire logic [10:0] fifo_level_limit_i,
    input  wire logic        fifo_flag_autoclear_en_i,
    output logic             fifo_push_ok_o,
    output logic             fifo_flush_o,
    output logic      [10:0] fifo_byte_count_o,
    // slot traffic
    input  wire logic [11:0] slot_update_i,
    input  wire logic [11:0] slot_read_i,
    input  wire logic [11:0] slot_update_autoclear_en_i,
    // flag state
    output logic             fifo_underflow_flag_o,
    output logic             fifo_overflow_flag_o,
    output logic             fifo_level_flag_o,
    output logic      [11:0] slot_update_flags_o
);
    // count arithmetic is one bit wider than the count field
    if (FIFO_DEPTH > 2047 || FIFO_DEPTH < 1 || WR_BYTES < 1 || WR_BYTES > FIFO_DEPTH)
    begin : g_bad_param
        $error("sfi_status_top: depth must be 1..2047 and write size 1..depth");
    end

    localparam logic [11:0] DEPTH_C = 12'(FIFO_DEPTH);
    localparam logic [11:0] WRB_C   = 12'(WR_BYTES);

    typedef struct packed {
        logic [10:0] cnt;
        logic        flush;
        logic        push_ok;
        logic        rvalid;
        logic [15:0] rdata;
    } sfi_top_st_t;

    sfi_top_st_t st_q;
    sfi_top_st_t st_d;

    sfi_flag_if #(.N(sfi_pkg::FLAG_N)) flg ();

    sfi_flag_bank #(
        .N         (sfi_pkg::FLAG_N)
    ) u_flags (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .ce_i      (ce_i),
        .flg       (flg)
    );

    logic        wr_state;
    logic        wr_event;
    logic        flush;
    logic        room;
    logic        push_ok;
    logic        pop_ok;
    logic        uflow_set;
    logic        oflow_set;
    logic        level_set;
    logic [11:0] cnt_wide;
    logic [11:0] cnt_next;

    // register write decode
    assign wr_state = reg_wr_i && (reg_addr_i == sfi_pkg::FIFO_STATE_OFS);
    assign wr_event = reg_wr_i && (reg_addr_i == sfi_pkg::DATA_EVENT_OFS);
    assign flush    = wr_state && reg_wdata_i[sfi_pkg::FLUSH_BIT];

    // fifo accounting; a flush is assumed never to meet fifo traffic, but it wins anyway
    assign cnt_wide  = {1'b0, st_q.cnt};
    assign room      = (cnt_wide + WRB_C) <= DEPTH_C;
    assign push_ok   = fifo_push_i && room && !flush;
    assign pop_ok    = fifo_pop_i && (st_q.cnt != '0) && !flush;
    assign uflow_set = fifo_pop_i && (st_q.cnt == '0) && !flush;
    assign oflow_set = fifo_push_i && !room && !flush;
    assign cnt_next  = flush ? 12'h0000 : (cnt_wide + (push_ok ? WRB_C : 12'h0000) - {11'h000, pop_ok});
    // compare the count that the write leaves behind
    assign level_set = push_ok && (cnt_next > {1'b0, fifo_level_limit_i});

    // flag set and clear requests
    always_comb
    begin
        flg.set = '0;
        flg.clr = '0;
        flg.set[sfi_pkg::SLOT_N-1:0] = slot_update_i;
        flg.set[sfi_pkg::FB_UFLOW]   = uflow_set;
        flg.set[sfi_pkg::FB_OFLOW]   = oflow_set;
        flg.set[sfi_pkg::FB_LEVEL]   = level_set;
        flg.clr[sfi_pkg::SLOT_N-1:0] = ({sfi_pkg::SLOT_N{wr_event}}
                                       & reg_wdata_i[sfi_pkg::SLOT_LSB +: sfi_pkg::SLOT_N])
                                     | (slot_read_i & slot_update_autoclear_en_i);
        flg.clr[sfi_pkg::FB_UFLOW]   = flush || (wr_state && reg_wdata_i[sfi_pkg::UFLOW_BIT]);
        flg.clr[sfi_pkg::FB_OFLOW]   = flush || (wr_state && reg_wdata_i[sfi_pkg::OFLOW_BIT]);
        flg.clr[sfi_pkg::FB_LEVEL]   = flush
                                     || (wr_event && reg_wdata_i[sfi_pkg::LEVEL_BIT])
                                     || (fifo_pop_i && fifo_flag_autoclear_en_i);
    end

    // next state and read mux; reads show the state before this cycle's updates
    always_comb
    begin
        st_d         = st_q;
        st_d.cnt     = cnt_next[10:0];
        st_d.flush   = flush;
        st_d.push_ok = push_ok;
        st_d.rvalid  = reg_rd_i;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                sfi_pkg::FIFO_STATE_OFS:
                begin
                    st_d.rdata = sfi_pkg::FIFO_STATE_RST;
                    st_d.rdata[sfi_pkg::UFLOW_BIT] = flg.q[sfi_pkg::FB_UFLOW];
                    st_d.rdata[sfi_pkg::OFLOW_BIT] = flg.q[sfi_pkg::FB_OFLOW];
                    st_d.rdata[sfi_pkg::COUNT_LSB +: sfi_pkg::COUNT_W] = st_q.cnt;
                end
                sfi_pkg::DATA_EVENT_OFS:
                begin
                    st_d.rdata = sfi_pkg::DATA_EVENT_RST;
                    st_d.rdata[sfi_pkg::LEVEL_BIT] = flg.q[sfi_pkg::FB_LEVEL];
                    st_d.rdata[sfi_pkg::SLOT_LSB +: sfi_pkg::SLOT_N] = flg.q[sfi_pkg::SLOT_N-1:0];
                end
                default:
                    st_d.rdata = 16'h0000;
            endcase
        end
    end

    // all state frozen while the enable is low
    always_ff @(posedge clk_sys_i)
    begin
        if (!rstn_i)
            st_q <= '0;
        else if (ce_i)
            st_q <= st_d;
    end

    // outputs straight from flops
    assign reg_rdata_o           = st_q.rdata;
    assign reg_rvalid_o          = st_q.rvalid;
    assign fifo_push_ok_o        = st_q.push_ok;
    assign fifo_flush_o          = st_q.flush;
    assign fifo_byte_count_o     = st_q.cnt;
    assign fifo_underflow_flag_o = flg.q[sfi_pkg::FB_UFLOW];
    assign fifo_overflow_flag_o  = flg.q[sfi_pkg::FB_OFLOW];
    assign fifo_level_flag_o     = flg.q[sfi_pkg::FB_LEVEL];
    assign slot_update_flags_o   = flg.q[sfi_pkg::SLOT_N-1:0];

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_flush_req;
        ce_i && flush;
    endsequence
    sequence s_fifo_empty;
        fifo_byte_count_o == 11'h000 && !fifo_underflow_flag_o && !fifo_overflow_flag_o && !fifo_level_flag_o;
    endsequence

    a_flush_empties: assert property (s_flush_req |=> s_fifo_empty ##0 fifo_flush_o)
        else $error("flush did not empty fifo state");

    a_uflow_on_empty: assert property ((ce_i && fifo_pop_i && fifo_byte_count_o == 11'h000 && !flush)
        |=> fifo_underflow_flag_o && fifo_byte_count_o == 11'h000)
        else $error("empty read did not flag underflow");

    a_oflow_drops: assert property ((ce_i && fifo_push_i && !room && !flush)
        |=> fifo_overflow_flag_o && !fifo_push_ok_o)
        else $error("full write not dropped and flagged");

    a_uflow_w1c: assert property ((ce_i && wr_state && reg_wdata_i[sfi_pkg::UFLOW_BIT] && !uflow_set)
        |=> !fifo_underflow_flag_o)
        else $error("underflow not cleared by write one");

    a_count_readback: assert property ((ce_i && reg_rd_i && reg_addr_i == sfi_pkg::FIFO_STATE_OFS)
        |=> reg_rvalid_o && reg_rdata_o[12:11] == 2'b00 && reg_rdata_o[10:0] == $past(fifo_byte_count_o))
        else $error("byte count readback wrong");

    a_level_on_write: assert property ((ce_i && push_ok && cnt_next > {1'b0, fifo_level_limit_i})
        |=> fifo_level_flag_o ##1 (fifo_level_flag_o || !ce_i || $past(flg.clr[sfi_pkg::FB_LEVEL])))
        else $error("level flag not set on write");

    a_level_autoclr: assert property ((ce_i && fifo_pop_i && fifo_flag_autoclear_en_i && !level_set)
        |=> !fifo_level_flag_o)
        else $error("level flag not auto-cleared");

    a_slot_autoclr: assert property ((ce_i && slot_read_i[0] && slot_update_autoclear_en_i[0] && !slot_update_i[0])
        |=> !slot_update_flags_o[0])
        else $error("slot flag not auto-cleared");

    a_event_reserved: assert property ((ce_i && reg_rd_i && reg_addr_i == sfi_pkg::DATA_EVENT_OFS)
        |=> reg_rdata_o[14:12] == 3'b000 && reg_rdata_o[11:0] == $past(slot_update_flags_o))
        else $error("data event readback wrong");

    a_level_w1c: assert property ((ce_i && wr_event && reg_wdata_i[sfi_pkg::LEVEL_BIT] && !level_set)
        |=> !fifo_level_flag_o)
        else $error("level flag not cleared by write one");

    a_slot_set: assert property ((ce_i && slot_update_i != 12'h000)
        |=> (slot_update_flags_o & $past(slot_update_i)) == $past(slot_update_i))
        else $error("slot update flag not set");

    // an accepted push without a pop grows the count by one write
    a_push_counts: assert property ((ce_i && fifo_push_i && !fifo_pop_i && room && !flush)
        |=> fifo_push_ok_o && fifo_byte_count_o == $past(fifo_byte_count_o) + WRB_C[10:0])
        else $error("accepted push miscounted");

    a_flush_zero_write: assert property ((ce_i && wr_state && !reg_wdata_i[sfi_pkg::FLUSH_BIT])
        |=> !fifo_flush_o)
        else $error("flush without a one written");

    a_slot_w1c: assert property ((ce_i && wr_event && reg_wdata_i[0] && !slot_update_i[0])
        |=> !slot_update_flags_o[0])
        else $error("slot flag not cleared by write one");
endmodule

// File: sfi_host_model.sv
`timescale 1ns/1ps
module sfi_host_model (
    // clock and read answer
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] reg_rdata_i,
    input  wire logic        reg_rvalid_i,
    // register requests
    output logic      [15:0] reg_addr_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic      [15:0] reg_wdata_o
);
    // idle bus carries junk, never a stale copy of the last request
    initial
    begin
        reg_addr_o  = 16'h5a5a;
        reg_wdata_o = 16'ha5a5;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end

    // one write strobe across one rising edge; callers flush only with fifo idle
    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_sys_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask

    // read answer stands for one cycle, so sample it before letting go
    task automatic rd_reg(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge clk_sys_i);
        d          = reg_rdata_i;
        v          = reg_rvalid_i;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
    endtask
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        wr;
    logic        rd;
    logic        rvalid;
    logic        push      = 1'b0;
    logic        pop       = 1'b0;
    logic        fifo_ac   = 1'b0;
    logic [10:0] limit     = 11'h004;
    logic        push_ok;
    logic        flush;
    logic        ok;
    logic [10:0] count;
    logic [11:0] slot_upd  = 12'h000;
    logic [11:0] slot_rd   = 12'h000;
    logic [11:0] slot_ac   = 12'h000;
    logic [11:0] slot_flags;
    logic [2:0]  flags;
    logic        ce        = 1'b1;
    logic [15:0] rd_seen;
    logic        rv_seen;
    int          n_mismatch = 0;
    int          tests_run  = 0;

    always #2 clk_sys_i = ~clk_sys_i;

    // small depth so four writes fill the fifo and the fifth overflows
    sfi_status_top #(.FIFO_DEPTH(8), .WR_BYTES(2)) uut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .fifo_push_i(push), .fifo_pop_i(pop), .fifo_level_limit_i(limit),
        .fifo_flag_autoclear_en_i(fifo_ac), .fifo_push_ok_o(push_ok), .fifo_flush_o(flush),
        .fifo_byte_count_o(count), .slot_update_i(slot_upd), .slot_read_i(slot_rd),
        .slot_update_autoclear_en_i(slot_ac), .fifo_underflow_flag_o(flags[0]),
        .fifo_overflow_flag_o(flags[1]), .fifo_level_flag_o(flags[2]), .slot_update_flags_o(slot_flags)
    );

    sfi_host_model host (
        .clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd), .reg_wdata_o(wdata)
    );

    task automatic close_out;
        if (n_mismatch == 0 && tests_run > 0)
        begin
            $display("Finished cleanly");
        end
        else
        begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // register read with its valid strobe checked as well
    task automatic rchk(input string nm, input logic [15:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic        v;
        host.rd_reg(a, d, v);
        chk("rvalid", 16'h0001, {15'h0000, v});
        chk(nm, e, d);
    endtask

    // one cycle of fifo and slot events, push result returned
    task automatic ev(input logic p, input logic q, input logic [11:0] su, input logic [11:0] sr, output logic k);
        @(negedge clk_sys_i);
        push     = p;
        pop      = q;
        slot_upd = su;
        slot_rd  = sr;
        @(negedge clk_sys_i);
        push     = 1'b0;
        pop      = 1'b0;
        slot_upd = 12'h000;
        slot_rd  = 12'h000;
        k        = push_ok;
    endtask

    // watchdog, far beyond the hundred or so cycles the tests need
    initial
    begin
        #20000;
        n_mismatch++;
        close_out();
    end

    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rstn_i = 1'b1;
        rchk("state reset", 16'h0000, 16'h0000);
        rchk("event reset", 16'h0001, 16'h0000);
        rchk("unmapped", 16'h0002, 16'h0000);
        ev(1'b0, 1'b1, 12'h000, 12'h000, ok);
        chk("underflow pin", 16'h0001, {15'h0000, flags[0]});
        rchk("underflow", 16'h0000, 16'h4000);
        host.wr_reg(16'h0000, 16'h0000);
        rchk("write zero", 16'h0000, 16'h4000);
        host.wr_reg(16'h0000, 16'h4000);
        chk("underflow pin clear", 16'h0000, {15'h0000, flags[0]});
        rchk("underflow clear", 16'h0000, 16'h0000);
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        chk("push accepted", 16'h0001, {15'h0000, ok});
        chk("count pin", 16'h0002, {5'h00, count});
        rchk("level below", 16'h0001, 16'h0000);
        // count equal to the limit does not exceed it
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        rchk("level at limit", 16'h0001, 16'h0000);
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        chk("level pin", 16'h0001, {15'h0000, flags[2]});
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        chk("push dropped", 16'h0000, {15'h0000, ok});
        chk("overflow pin", 16'h0001, {15'h0000, flags[1]});
        rchk("overflow count", 16'h0000, 16'h2008);
        host.wr_reg(16'h0000, 16'h3fff);
        rchk("count read only", 16'h0000, 16'h0008);
        rchk("level set", 16'h0001, 16'h8000);
        host.wr_reg(16'h0001, 16'h7000);
        rchk("reserved", 16'h0001, 16'h8000);
        host.wr_reg(16'h0001, 16'h8000);
        rchk("level w1c", 16'h0001, 16'h0000);
        // make room and raise the level flag again for the auto-clear
        ev(1'b0, 1'b1, 12'h000, 12'h000, ok);
        ev(1'b0, 1'b1, 12'h000, 12'h000, ok);
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        fifo_ac = 1'b1;
        ev(1'b0, 1'b1, 12'h000, 12'h000, ok);
        rchk("level autoclear", 16'h0001, 16'h0000);
        fifo_ac = 1'b0;
        ev(1'b0, 1'b1, 12'h000, 12'h000, ok);
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        // enable low: traffic and reads are ignored, state frozen
        ce = 1'b0;
        ev(1'b0, 1'b1, 12'h001, 12'h000, ok);
        host.rd_reg(16'h0000, rd_seen, rv_seen);
        ce = 1'b1;
        chk("frozen count", 16'h0008, {5'h00, count});
        chk("frozen slots", 16'h0000, {4'h0, slot_flags});
        chk("frozen read", 16'h0000, {15'h0000, rv_seen});
        host.wr_reg(16'h0000, 16'h8000);
        chk("flush pulse", 16'h0001, {15'h0000, flush});
        chk("flush count pin", 16'h0000, {5'h00, count});
        chk("flush flag pins", 16'h0000, {13'h0000, flags});
        rchk("flushed state", 16'h0000, 16'h0000);
        rchk("flushed level", 16'h0001, 16'h0000);
        ev(1'b0, 1'b0, 12'hfff, 12'h000, ok);
        chk("slot pins", 16'h0fff, {4'h0, slot_flags});
        rchk("slots set", 16'h0001, 16'h0fff);
        host.wr_reg(16'h0001, 16'h0002);
        rchk("slot b clear", 16'h0001, 16'h0ffd);
        slot_ac = 12'h801;
        ev(1'b0, 1'b0, 12'h000, 12'hfff, ok);
        rchk("slot autoclear", 16'h0001, 16'h07fc);
        host.wr_reg(16'h0001, 16'h0fff);
        fork
            host.wr_reg(16'h0001, 16'h0002);
            ev(1'b0, 1'b0, 12'h002, 12'h000, ok);
        join
        rchk("set wins", 16'h0001, 16'h0002);
        // second reset in mid-run with a count and a flag standing
        ev(1'b1, 1'b0, 12'h000, 12'h000, ok);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        chk("reset count pin", 16'h0000, {5'h00, count});
        chk("reset slot pins", 16'h0000, {4'h0, slot_flags});
        chk("reset flag pins", 16'h0000, {13'h0000, flags});
        chk("reset rvalid", 16'h0000, {15'h0000, rvalid});
        rchk("reset state", 16'h0000, 16'h0000);
        rchk("reset event", 16'h0001, 16'h0000);
        close_out();
    end
endmodule
